// [core/port_pkg.sv]
// Purpose: shared constants for the general-purpose port block
// Assumes: one port of up to eight pins, byte-wide register port
// Notes:   offsets are word indexes on the plain register port
`default_nettype none
package port_pkg;
  localparam int unsigned PIN_COUNT   = 8;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 8;
  // register offsets
  localparam logic [3:0]  OFS_PIN_IN  = 4'h0;
  localparam logic [3:0]  OFS_DIR     = 4'h1;
  localparam logic [3:0]  OFS_OUT     = 4'h2;
  localparam logic [3:0]  OFS_MCU_CTL = 4'h3;
  localparam logic [3:0]  OFS_STATUS  = 4'h4;
  // mcu_control field positions
  localparam int unsigned BIT_VEC_CHG_EN = 0;
  localparam int unsigned BIT_VEC_SEL    = 1;
  localparam int unsigned BIT_PULLUP_DIS = 4;
  localparam int unsigned BIT_DBG_OFF    = 7;
  localparam logic [7:0]  MCU_CTL_WMASK = 8'h93;
  // reset values
  localparam logic [7:0]  RST_MCU_CTL = 8'h00;
  localparam logic [7:0]  RST_DIR     = 8'h00;
  localparam logic [7:0]  RST_OUT     = 8'h00;
  localparam logic [7:0]  RST_DATA    = 8'h00;
  // pull-up enable pattern {dir_bit, out_bit, pullup_disable_all}
  localparam logic [2:0]  PU_ON_CODE  = 3'b010;
  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_IDLE,
    MODE_CLAMP
  } sleep_mode_e;
endpackage
`default_nettype wire

// [core/pin_sync.sv]
// Purpose: two-stage input synchroniser for the pin levels
// Assumes: latch transparent while clock high modelled as a negedge stage
// Notes:   the first stage is read only by the second
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1_r;

  // capture at falling edge: half-cycle latch stage
  always_ff @(negedge ref_clk) begin
    stage1_r <= d;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= stage1_r;
    end
  end
endmodule
`default_nettype wire

// [core/pin_cell.sv]
// Purpose: per-pin combinational override and drive logic
// Assumes: override signals come from the owning peripheral
// Notes:   pure combinational, one instance per pin
`default_nettype none
module pin_cell (
  // register state
  input  wire logic dir_bit,
  input  wire logic out_bit,
  input  wire logic pullup_disable_all,
  input  wire logic in_reset,
  input  wire logic sleep_clamp,
  input  wire logic ext_irq_en,
  // overrides
  input  wire logic pullup_override_en,
  input  wire logic pullup_override_val,
  input  wire logic dir_override_en,
  input  wire logic dir_override_val,
  input  wire logic value_override_en,
  input  wire logic value_override_val,
  input  wire logic input_en_override_en,
  input  wire logic input_en_override_val,
  // pad side
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pullup,
  output logic      schmitt_out
);
  logic drv_en;
  logic pu_en;
  logic in_en;

  always_comb begin
    // driver enable
    drv_en = dir_override_en ? dir_override_val : dir_bit;
    // pull-up
    pu_en  = pullup_override_en ? pullup_override_val
           : ({dir_bit, out_bit, pullup_disable_all} == port_pkg::PU_ON_CODE);
    // input enable: an armed interrupt keeps the pin awake
    in_en  = input_en_override_en ? input_en_override_val : (!sleep_clamp || ext_irq_en);
  end

  // reset forces tri-state and drops the pull-up
  assign pad_oe      = drv_en && !in_reset;
  assign pad_pullup  = pu_en && !in_reset;
  assign pad_out     = value_override_en ? value_override_val : out_bit;
  // clamp to ground ahead of the trigger; release makes an edge
  assign schmitt_out = pad_in && in_en;
endmodule
`default_nettype wire

// [core/port_pin_override_logic.sv]
// Purpose: one general-purpose port with alternate-function overrides
// Assumes: single clock ref_clk, synchronous active-high srst
// Notes:   pad drive is combinational from reset so pins float at once
`default_nettype none
// Overview of operation
// - clamp inputs to ground in deep sleep
// - armed external interrupt overrides the clamp
// - clamp release may set interrupt flag
// - pull-ups off while reset is active
// - pull-up from override or 010 pattern
// - pull-up override value wins over registers
// - driver enable from override or dir_bit
// - direction override value ignores dir_bit
// - driven level from override or out_bit
// - value override ignores stored out_bit
// - toggle override inverts stored out_bit
// - input enable from override or sleep state
// - input enable override ignores sleep state
// - alt input taken before the synchroniser
// - global pull-up disable bit in control
// - strobes per port, clamp shared globally
// - peripherals generate overrides for their pins
// - dir_bit one output, zero input
// - writing one to pin input toggles out_bit
// - pins tri-stated whenever reset is active
// - latch then flip-flop input synchroniser
module port_pin_override_logic
  import port_pkg::*;
#(
  parameter int unsigned PINS = port_pkg::PIN_COUNT
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // register port
  input  wire logic [port_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [port_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        port_write_strobe,
  input  wire logic                        port_read_strobe,
  output logic      [port_pkg::DATA_W-1:0] reg_rdata,
  // sleep controller and interrupt enables
  input  wire port_pkg::sleep_mode_e       sleep_mode,
  input  wire logic [PINS-1:0]             ext_irq_en,
  // alternate-function overrides, zero where absent
  input  wire logic [PINS-1:0]             pullup_override_en,
  input  wire logic [PINS-1:0]             pullup_override_val,
  input  wire logic [PINS-1:0]             dir_override_en,
  input  wire logic [PINS-1:0]             dir_override_val,
  input  wire logic [PINS-1:0]             value_override_en,
  input  wire logic [PINS-1:0]             value_override_val,
  input  wire logic [PINS-1:0]             toggle_override_en,
  input  wire logic [PINS-1:0]             input_en_override_en,
  input  wire logic [PINS-1:0]             input_en_override_val,
  output logic      [PINS-1:0]             alt_digital_in,
  // pads
  input  wire logic [PINS-1:0]             pad_in,
  output logic      [PINS-1:0]             pad_out,
  output logic      [PINS-1:0]             pad_oe,
  output logic      [PINS-1:0]             pad_pullup,
  // global control seen by the rest of the chip
  output logic                             pullup_disable_all,
  output logic                             sleep_clamp
);
  import port_pkg::*;

  logic [PINS-1:0] dir_r;
  logic [PINS-1:0] out_r;
  logic [PINS-1:0] out_nxt;
  logic [7:0]      mcu_ctl_r;
  logic [PINS-1:0] pin_in_bit;
  logic [PINS-1:0] schmitt;
  logic            wr_dir;
  logic            wr_out;
  logic            wr_pin;
  logic            wr_ctl;

  // decode shared by every pin of the port
  assign wr_dir = port_write_strobe && (reg_addr == OFS_DIR);
  assign wr_out = port_write_strobe && (reg_addr == OFS_OUT);
  assign wr_pin = port_write_strobe && (reg_addr == OFS_PIN_IN);
  assign wr_ctl = port_write_strobe && (reg_addr == OFS_MCU_CTL);

  // one clamp and one pull-up disable for all ports
  assign sleep_clamp        = (sleep_mode == MODE_CLAMP);
  assign pullup_disable_all = mcu_ctl_r[BIT_PULLUP_DIS];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dir_r <= RST_DIR[PINS-1:0];
    end else if (wr_dir) begin
      dir_r <= reg_wdata[PINS-1:0];
    end
  end

  always_comb begin
    out_nxt = out_r;
    if (wr_out) begin
      out_nxt = reg_wdata[PINS-1:0];
    end
    // a register write and a toggle in the same cycle: toggle applies on top
    if (wr_pin) begin
      out_nxt = out_nxt ^ reg_wdata[PINS-1:0];
    end
    out_nxt = out_nxt ^ toggle_override_en;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_r <= RST_OUT[PINS-1:0];
    end else begin
      out_r <= out_nxt;
    end
  end

  // read-only bits stay zero whatever is written
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mcu_ctl_r <= RST_MCU_CTL;
    end else if (wr_ctl) begin
      mcu_ctl_r <= reg_wdata & MCU_CTL_WMASK;
    end
  end

  // readback lags the pad by the synchroniser; software allows one idle cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= RST_DATA;
    end else if (port_read_strobe) begin
      case (reg_addr)
        OFS_PIN_IN:  reg_rdata <= DATA_W'(pin_in_bit);
        OFS_DIR:     reg_rdata <= DATA_W'(dir_r);
        OFS_OUT:     reg_rdata <= DATA_W'(out_r);
        OFS_MCU_CTL: reg_rdata <= mcu_ctl_r;
        OFS_STATUS:  reg_rdata <= DATA_W'(pad_oe);
        default:     reg_rdata <= RST_DATA;
      endcase
    end else begin
      reg_rdata <= RST_DATA;
    end
  end

  // overrides come from the peripherals owning each pin
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      pin_cell u_cell (
        .dir_bit               (dir_r[i]),
        .out_bit               (out_r[i]),
        .pullup_disable_all    (pullup_disable_all),
        .in_reset              (srst),
        .sleep_clamp           (sleep_clamp),
        .ext_irq_en            (ext_irq_en[i]),
        .pullup_override_en    (pullup_override_en[i]),
        .pullup_override_val   (pullup_override_val[i]),
        .dir_override_en       (dir_override_en[i]),
        .dir_override_val      (dir_override_val[i]),
        .value_override_en     (value_override_en[i]),
        .value_override_val    (value_override_val[i]),
        .input_en_override_en  (input_en_override_en[i]),
        .input_en_override_val (input_en_override_val[i]),
        .pad_in                (pad_in[i]),
        .pad_out               (pad_out[i]),
        .pad_oe                (pad_oe[i]),
        .pad_pullup            (pad_pullup[i]),
        .schmitt_out           (schmitt[i])
      );
    end
  endgenerate

  // unsynchronised; consumers synchronise unless used as a clock
  assign alt_digital_in = schmitt;

  pin_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .d       (schmitt),
    .q       (pin_in_bit)
  );
endmodule
`default_nettype wire

// [test/port_pin_override_logic_props.sv]
// Purpose: checker for the port pin override logic
// Assumes: one clock, pads combinational from registers and overrides
// Notes:   bound to the top module, sees its ports only
`default_nettype none
module port_pin_override_logic_props
  import port_pkg::*;
#(
  parameter int unsigned PINS = 8
) (
  // clock, reset and globals
  input wire logic            ref_clk,
  input wire logic            srst,
  input wire logic            pullup_disable_all,
  input wire logic            sleep_clamp,
  input wire sleep_mode_e     sleep_mode,
  // overrides
  input wire logic [PINS-1:0] ext_irq_en,
  input wire logic [PINS-1:0] pullup_override_en,
  input wire logic [PINS-1:0] pullup_override_val,
  input wire logic [PINS-1:0] dir_override_en,
  input wire logic [PINS-1:0] dir_override_val,
  input wire logic [PINS-1:0] value_override_en,
  input wire logic [PINS-1:0] value_override_val,
  input wire logic [PINS-1:0] input_en_override_en,
  input wire logic [PINS-1:0] input_en_override_val,
  // pads
  input wire logic [PINS-1:0] pad_in,
  input wire logic [PINS-1:0] alt_digital_in,
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic [PINS-1:0] pad_pullup
);
  default clocking @(posedge ref_clk); endclocking
  chk_reset_float: assert property (srst |-> pad_oe == '0)
    else $error("pin driven in reset");
  chk_reset_pullup: assert property (srst |-> pad_pullup == '0)
    else $error("pull-up on in reset");
  chk_pullup_force: assert property (disable iff (srst)
    (pad_pullup & pullup_override_en) == (pullup_override_val & pullup_override_en)) else $error("pull-up override");
  chk_pud_global: assert property (disable iff (srst)
    pullup_disable_all |-> (pad_pullup & ~pullup_override_en) == '0) else $error("pull-up despite disable");
  chk_dir_force: assert property (disable iff (srst)
    (pad_oe & dir_override_en) == (dir_override_val & dir_override_en)) else $error("direction override");
  chk_value_force: assert property (disable iff (srst)
    (pad_out & pad_oe & value_override_en) == (value_override_val & pad_oe & value_override_en)) else $error("value");
  chk_clamp_input: assert property (disable iff (srst)
    sleep_clamp |-> (alt_digital_in & ~ext_irq_en & ~input_en_override_en) == '0) else $error("input not clamped");
  chk_irq_unclamp: assert property (disable iff (srst)
    (alt_digital_in & ext_irq_en & ~input_en_override_en) == (pad_in & ext_irq_en & ~input_en_override_en))
    else $error("armed pin clamped");
  chk_input_force: assert property (disable iff (srst)
    (alt_digital_in & input_en_override_en) == (pad_in & input_en_override_val & input_en_override_en))
    else $error("input enable override");
  chk_clamp_mode: assert property (disable iff (srst)
    sleep_clamp == (sleep_mode == MODE_CLAMP)) else $error("clamp does not follow mode");
endmodule
bind port_pin_override_logic port_pin_override_logic_props #(
  .PINS (PINS)
) chk (
  .ref_clk               (ref_clk),
  .srst                  (srst),
  .pullup_disable_all    (pullup_disable_all),
  .sleep_clamp           (sleep_clamp),
  .sleep_mode            (sleep_mode),
  .ext_irq_en            (ext_irq_en),
  .pullup_override_en    (pullup_override_en),
  .pullup_override_val   (pullup_override_val),
  .dir_override_en       (dir_override_en),
  .dir_override_val      (dir_override_val),
  .value_override_en     (value_override_en),
  .value_override_val    (value_override_val),
  .input_en_override_en  (input_en_override_en),
  .input_en_override_val (input_en_override_val),
  .pad_in                (pad_in),
  .alt_digital_in        (alt_digital_in),
  .pad_out               (pad_out),
  .pad_oe                (pad_oe),
  .pad_pullup            (pad_pullup)
);
`default_nettype wire

// [test/pad_partner.sv]
// Purpose: pins and outside circuitry of the port
// Assumes: the port driver wins over any outside drive
// Notes:   pins with no driver and no pull wander every cycle
`default_nettype none
module pad_partner #(
  parameter int unsigned PINS = 8
) (
  // clock
  input  wire logic            ref_clk,
  // pad side
  input  wire logic [PINS-1:0] pad_out,
  input  wire logic [PINS-1:0] pad_oe,
  input  wire logic [PINS-1:0] pad_pullup,
  // outside drive
  input  wire logic [PINS-1:0] ext_en,
  input  wire logic [PINS-1:0] ext_val,
  output logic      [PINS-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [PINS-1:0] float_r = '0;
  // a floating pin never holds its last level, so a stale value cannot pass
  always @(posedge ref_clk) begin
    float_r <= ~float_r;
  end
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pad_pullup | float_r));
endmodule
`default_nettype wire

// [test/port_pin_override_logic_test.sv]
// Purpose: self-checking bench for the port pin override logic
// Assumes: plain register port, read data the cycle after the strobe
// Notes:   pins 4..7 held by the outside unless the port drives them
`default_nettype none
module port_pin_override_logic_test;
  timeunit 1ns;
  timeprecision 100ps;
  import port_pkg::*;
  logic        ref_clk = 0, srst = 1, port_write_strobe = 0, port_read_strobe = 0, pullup_disable_all, sleep_clamp;
  logic [3:0]  reg_addr = '0;
  logic [7:0]  reg_wdata = '0, reg_rdata, alt_digital_in, pad_in, pad_out, pad_oe, pad_pullup, ext_en = 8'hF0;
  logic [7:0]  ext_irq_en = '0, pullup_override_en = '0, pullup_override_val = '0, dir_override_en = '0;
  logic [7:0]  dir_override_val = '0, value_override_en = '0, value_override_val = '0, toggle_override_en = '0;
  logic [7:0]  input_en_override_en = '0, input_en_override_val = '0, ext_val = 8'h40;
  sleep_mode_e sleep_mode = MODE_ACTIVE;
  int          n_errors = 0, checks_done = 0;
  always #2 ref_clk = ~ref_clk;
  port_pin_override_logic dut (.*);
  pad_partner pads (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    port_write_strobe <= 1'b1;
    @(posedge ref_clk);
    port_write_strobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    port_read_strobe <= 1'b1;
    @(posedge ref_clk);
    port_read_strobe <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(OFS_DIR, RST_DIR);
    rd(OFS_MCU_CTL, RST_MCU_CTL);
    rd(4'hF, 8'h00);
    $display("reset values done");
    wr(OFS_DIR, 8'h0F);
    wr(OFS_OUT, 8'h33);
    check(pad_oe, 8'h0F);
    check(pad_pullup, 8'h30);
    check(pad_out & pad_oe, 8'h03);
    rd(OFS_PIN_IN, 8'h43);
    rd(OFS_STATUS, 8'h0F);
    wr(OFS_MCU_CTL, 8'hFF);
    check(pad_pullup, 8'h00);
    check({7'h00, pullup_disable_all}, 8'h01);
    rd(OFS_MCU_CTL, MCU_CTL_WMASK);
    #4 check(reg_rdata, RST_DATA);
    wr(OFS_MCU_CTL, 8'h00);
    wr(OFS_PIN_IN, 8'h81);
    rd(OFS_OUT, 8'hB2);
    @(posedge ref_clk);
    toggle_override_en <= 8'h0F;
    @(posedge ref_clk);
    toggle_override_en <= 8'h00;
    rd(OFS_OUT, 8'hBD);
    $display("register control done");
    pullup_override_en <= 8'hFF;
    pullup_override_val <= 8'hA5;
    dir_override_en <= 8'hF0;
    dir_override_val <= 8'h30;
    value_override_en <= 8'h3C;
    value_override_val <= 8'h14;
    #4 check(pad_pullup, 8'hA5);
    check(pad_oe, 8'h3F);
    check(pad_out & pad_oe, 8'h15);
    {pullup_override_en, dir_override_en, value_override_en} <= '0;
    sleep_mode <= MODE_CLAMP;
    ext_irq_en <= 8'h03;
    input_en_override_en <= 8'h30;
    input_en_override_val <= 8'h10;
    ext_val <= 8'hF0;
    #4 check(alt_digital_in, 8'h11);
    check({7'h00, sleep_clamp}, 8'h01);
    sleep_mode <= MODE_IDLE;
    #4 check(alt_digital_in, 8'hDD);
    $display("overrides and sleep done");
    check(pad_pullup, 8'hB0);
    @(posedge ref_clk);
    srst <= 1'b1;
    #1 check(pad_oe, 8'h00);
    check(pad_pullup, 8'h00);
    @(posedge ref_clk);
    srst <= 1'b0;
    rd(OFS_OUT, RST_OUT);
    $display("mid-run reset done");
    report_and_stop();
  end
  initial begin
    repeat (400) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
